// ### common/bcs_consts.vh
`ifndef BCS_CONSTS_VH
`define BCS_CONSTS_VH

// ----------------------------------------
// Cycle status codes, high bit first
// ----------------------------------------
`define BCS_ST_INTA    3'h0
`define BCS_ST_IO_RD   3'h1
`define BCS_ST_IO_WR   3'h2
`define BCS_ST_HALT    3'h3
`define BCS_ST_FETCH   3'h4
`define BCS_ST_MEM_RD  3'h5
`define BCS_ST_MEM_WR  3'h6
`define BCS_ST_PASSIVE 3'h7

// ----------------------------------------
// Field widths and pin levels
// ----------------------------------------
`define BCS_STATUS_W   3
`define BCS_STATE_W    4
`define BCS_RQ_ACTIVE  1'h0
`define BCS_RQ_IDLE    1'h1

`endif

// ### core/bcs_status_encoder.v
// Operation
// - Drive the active cycle code during T4, T1 and T2 of every cycle.
// - Status goes passive 111 in T3, or in the clock after a wait state that sees ready high.
// - 000 irq ack, 001/010 io rd/wr, 011 halt, 100 fetch, 101/110 mem rd/wr, 111 passive.
// - Status lines float for the whole of hold acknowledge.
// - First clock of reset drives all three status lines high.
// - After that first reset clock the status lines float.
// - Request pulse gets a one-clock grant after T3, the clock after a wait, or idle, then hold.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_consts.vh"

module bcs_status_encoder (
	// Clock and reset
	input  wire                       core_clk,
	input  wire                       srst,
	// Cycle request from the execution side
	input  wire                       cycle_valid,
	input  wire [`BCS_STATUS_W-1:0]   cycle_kind,
	output reg                        cycle_taken,
	output reg                        cycle_end,
	// Ready from the addressed slave
	input  wire                       ready,
	// Cycle status pins
	output reg  [`BCS_STATUS_W-1:0]   cycle_status_lines,
	output reg                        cycle_status_oe,
	// Request/grant pin, active low pulses
	input  wire                       bus_request_grant_line_in,
	output reg                        bus_request_grant_line_out,
	output reg                        bus_request_grant_line_oe,
	// Observation
	output reg                        hold_active,
	output reg  [`BCS_STATE_W-1:0]    bus_state
);

	// ----------------------------------------
	// Bus states
	// ----------------------------------------
	localparam [3:0] S_IDLE  = 4'h0;
	localparam [3:0] S_T4    = 4'h1;
	localparam [3:0] S_T1    = 4'h2;
	localparam [3:0] S_T2    = 4'h3;
	localparam [3:0] S_T3    = 4'h4;
	localparam [3:0] S_TW    = 4'h5;
	localparam [3:0] S_TWL   = 4'h6;
	localparam [3:0] S_GRANT = 4'h7;
	localparam [3:0] S_HOLD  = 4'h8;

	// ----------------------------------------
	// State and next values
	// ----------------------------------------
	reg  [3:0]               state;
	reg  [3:0]               next_state;
	reg  [`BCS_STATUS_W-1:0] kind;
	reg  [`BCS_STATUS_W-1:0] next_kind;
	reg  [`BCS_STATUS_W-1:0] next_status;
	reg                      next_status_oe;
	reg                      next_grant;
	reg                      next_taken;
	reg                      next_end;
	reg                      hold_pend;
	reg                      next_hold_pend;
	reg                      rst_seen;
	wire                     rq_seen;
	wire                     cycle_ok;

	// ----------------------------------------
	// Pin decode
	// ----------------------------------------
	// Our own grant pulse must not count as a request
	assign rq_seen  = (bus_request_grant_line_in == `BCS_RQ_ACTIVE) &&
	                  !bus_request_grant_line_oe;
	// A passive code is no cycle at all
	assign cycle_ok = cycle_valid && (cycle_kind != `BCS_ST_PASSIVE);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always @* begin
		next_state     = state;
		next_kind      = kind;
		// Passive by default, so unlisted paths stay safe
		next_status    = `BCS_ST_PASSIVE;
		next_status_oe = 1'h1;
		next_grant     = 1'h0;
		next_taken     = 1'h0;
		next_end       = 1'h0;
		next_hold_pend = hold_pend;
		// Pending request, clear wins over set
		if (rq_seen && (state != S_HOLD)) begin
			next_hold_pend = 1'h1;
		end
		case (state)
			S_IDLE: begin
				if (hold_pend || rq_seen) begin
					next_state     = S_GRANT;
					next_grant     = 1'h1;
					next_hold_pend = 1'h0;
				end else if (cycle_ok) begin
					next_state  = S_T4;
					next_kind   = cycle_kind;
					next_status = cycle_kind;
					next_taken  = 1'h1;
				end
			end
			S_T4: begin
				next_state  = S_T1;
				next_status = kind;
			end
			S_T1: begin
				next_state  = S_T2;
				next_status = kind;
			end
			S_T2: begin
				if (ready) begin
					next_state = S_T3;
					next_end   = 1'h1;
				end else begin
					// Code stays up while waiting
					next_state  = S_TW;
					next_status = kind;
				end
			end
			S_TW: begin
				// No wait limit; a slave that never readies stalls the bus
				if (ready) begin
					next_state = S_TWL;
					next_end   = 1'h1;
				end else begin
					next_status = kind;
				end
			end
			S_T3, S_TWL: begin
				// Request beats a new cycle so masters are not starved
				if (hold_pend || rq_seen) begin
					next_state     = S_GRANT;
					next_grant     = 1'h1;
					next_hold_pend = 1'h0;
				end else if (cycle_ok) begin
					next_state  = S_T4;
					next_kind   = cycle_kind;
					next_status = cycle_kind;
					next_taken  = 1'h1;
				end else begin
					next_state = S_IDLE;
				end
			end
			S_GRANT: begin
				next_state     = S_HOLD;
				next_status_oe = 1'h0;
			end
			S_HOLD: begin
				if (rq_seen) begin
					// One idle clock before the next cycle
					next_state     = S_IDLE;
					next_hold_pend = 1'h0;
				end else begin
					next_status_oe = 1'h0;
				end
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (srst) begin
			state                      <= S_IDLE;
			kind                       <= `BCS_ST_PASSIVE;
			hold_pend                  <= 1'h0;
			rst_seen                   <= 1'h1;
			cycle_status_lines         <= `BCS_ST_PASSIVE;
			// float after that
			// Unknown history at power-up falls to the drive branch
			if (rst_seen) begin
				cycle_status_oe        <= 1'h0;
			end else begin
				cycle_status_oe        <= 1'h1;
			end
			bus_request_grant_line_out <= `BCS_RQ_IDLE;
			bus_request_grant_line_oe  <= 1'h0;
			cycle_taken                <= 1'h0;
			cycle_end                  <= 1'h0;
			hold_active                <= 1'h0;
			bus_state                  <= S_IDLE;
		end else begin
			state                      <= next_state;
			kind                       <= next_kind;
			hold_pend                  <= next_hold_pend;
			rst_seen                   <= 1'h0;
			cycle_status_lines         <= next_status;
			cycle_status_oe            <= next_status_oe;
			bus_request_grant_line_out <= next_grant ? `BCS_RQ_ACTIVE : `BCS_RQ_IDLE;
			bus_request_grant_line_oe  <= next_grant;
			cycle_taken                <= next_taken;
			cycle_end                  <= next_end;
			hold_active                <= (next_state == S_HOLD);
			bus_state                  <= next_state;
		end
	end

endmodule

`default_nettype wire

// ### test/bcs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bcs_monitor (
	// Clock, reset
	input wire logic	core_clk,
	input wire logic	srst,
	// Cycle side
	input wire logic [2:0]	cycle_kind,
	input wire logic	cycle_taken,
	input wire logic	cycle_end,
	input wire logic [3:0]	bus_state,
	// Pins
	input wire logic [2:0]	cycle_status_lines,
	input wire logic	cycle_status_oe,
	input wire logic	bus_request_grant_line_in,
	input wire logic	bus_request_grant_line_oe,
	input wire logic	hold_active
);
	default clocking cb @(posedge core_clk); endclocking
	a_code_match: assert property (disable iff (srst)
		cycle_taken |-> cycle_status_lines == $past(cycle_kind)) else $error("bad code");
	a_code_hold: assert property (disable iff (srst)
		cycle_taken |=> $stable(cycle_status_lines) [*2]) else $error("code moved");
	a_end_passive: assert property (disable iff (srst)
		cycle_end |-> cycle_status_oe && cycle_status_lines == 3'h7) else $error("end not passive");
	a_end_bound: assert property (disable iff (srst)
		cycle_taken |-> ##[3:20] cycle_end) else $error("no end");
	a_hold_float: assert property (disable iff (srst)
		hold_active |-> !cycle_status_oe) else $error("driven in hold");
	// Reset checks keep running in reset
	a_reset_high: assert property (
		srst && !$past(srst) |=> cycle_status_oe && cycle_status_lines == 3'h7) else $error("not high");
	a_reset_float: assert property (
		srst && $past(srst) |=> !cycle_status_oe) else $error("not float");
	a_grant_idle: assert property (disable iff (srst)
		bus_state == 4'h0 && !bus_request_grant_line_in |=> bus_request_grant_line_oe ##1 hold_active)
		else $error("no grant");
	a_grant_hold: assert property (disable iff (srst)
		bus_request_grant_line_oe |-> cycle_status_oe && cycle_status_lines == 3'h7
		##1 hold_active && !cycle_status_oe) else $error("grant not followed by hold");
	cover property (cycle_end);
	cover property (bus_state == 4'h5);
	cover property (hold_active);
	cover property (cycle_end ##1 bus_request_grant_line_oe);
endmodule
`default_nettype wire

// ### test/bcs_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module bcs_ctl_model (
	// Clock, reset
	input wire logic	core_clk,
	input wire logic	srst,
	// Status pins, ready, decode
	input wire logic [2:0]	st,
	input wire logic	oe,
	input wire logic [3:0]	waits,
	output logic		ready,
	output logic [2:0]	kind_seen,
	output logic [7:0]	n_end
);
	logic [2:0]	prev;
	logic [4:0]	cnt;
	// Floating lines read as passive
	assign ready = cnt >= {1'b0, waits} + 5'h2;
	always @(posedge core_clk) begin
		prev <= oe ? st : 3'h7;
		cnt <= (oe && st != 3'h7) ? cnt + 5'h1 : 5'h0;
		if (srst)
			n_end <= 8'h0;
		else if (oe && st != 3'h7 && prev == 3'h7)
			kind_seen <= st;
		else if (oe && st == 3'h7 && prev != 3'h7)
			n_end <= n_end + 8'h1;
	end
endmodule
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic		core_clk, srst, cycle_valid, rq_drv, ready, taken, c_end, oe, g_out, g_oe, hold;
	logic [2:0]	cycle_kind, st, kind_seen;
	logic [3:0]	bus_state, waits;
	logic [7:0]	n_end, e0;
	int		err_total, tests_run, i;
	// Pull-up on the request/grant wire
	wire		rqg = rq_drv & (g_oe ? g_out : 1'b1);
	bcs_status_encoder u_bcs_status_encoder (.core_clk(core_clk), .srst(srst), .cycle_valid(cycle_valid),
		.cycle_kind(cycle_kind), .cycle_taken(taken), .cycle_end(c_end), .ready(ready),
		.cycle_status_lines(st), .cycle_status_oe(oe), .bus_request_grant_line_in(rqg),
		.bus_request_grant_line_out(g_out), .bus_request_grant_line_oe(g_oe), .hold_active(hold),
		.bus_state(bus_state));
	bcs_ctl_model u_bcs_ctl_model (.core_clk(core_clk), .srst(srst), .st(st), .oe(oe), .waits(waits),
		.ready(ready), .kind_seen(kind_seen), .n_end(n_end));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	task tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task check(input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("Error %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task tally_and_finish;
		$display("tests_run %0d err_total %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task do_reset;
		srst <= 1'b1;
		tick(1);
		#1 check(8'({oe, st}), 8'h0f);
		tick(1);
		#1 check(8'(oe), 8'h00);
		tick(2);
		srst <= 1'b0;
		tick(1);
	endtask
	task run_cycle(input logic [2:0] k, input logic [3:0] w);
		tick(1);
		e0 = n_end;
		waits <= w;
		cycle_valid <= 1'b1;
		cycle_kind <= k;
		i = 0;
		do begin
			tick(1);
			#1 i++;
		end while (taken !== 1'b1 && i < 20);
		check(8'(st), 8'(k));
		tick(1);
		cycle_valid <= 1'b0;
		i = 1;
		do begin
			tick(1);
			#1 i++;
		end while (c_end !== 1'b1 && i < 20);
		check(8'(i), 8'(w) + 8'h3);
		check(8'(st), 8'h07);
		tick(1);
		#1 check(8'(kind_seen), 8'(k));
		check(n_end, e0 + 8'h1);
	endtask
	task hold_seq;
		tick(1);
		rq_drv <= 1'b0;
		tick(1);
		rq_drv <= 1'b1;
		#1 check(8'({g_oe, g_out}), 8'h02);
		tick(1);
		#1 check(8'({hold, oe}), 8'h02);
		tick(2);
		rq_drv <= 1'b0;
		tick(1);
		rq_drv <= 1'b1;
		#1 check(8'({hold, oe}), 8'h01);
		tick(1);
	endtask
	task hold_mid_cycle;
		tick(1);
		e0 = n_end;
		waits <= 4'h1;
		cycle_valid <= 1'b1;
		cycle_kind <= 3'h5;
		tick(1);
		cycle_valid <= 1'b0;
		rq_drv <= 1'b0;
		tick(1);
		rq_drv <= 1'b1;
		i = 0;
		do begin
			tick(1);
			#1 i++;
		end while (c_end !== 1'b1 && i < 20);
		check(8'(i), 8'h03);
		tick(1);
		#1 check(8'({g_oe, g_out}), 8'h02);
		check(8'({oe, st}), 8'h0f);
		check(n_end, e0 + 8'h1);
		tick(1);
		#1 check(8'({hold, oe}), 8'h02);
		tick(1);
		rq_drv <= 1'b0;
		tick(1);
		rq_drv <= 1'b1;
		#1 check(8'({hold, oe}), 8'h01);
	endtask
	task passive_refused;
		tick(1);
		cycle_valid <= 1'b1;
		cycle_kind <= 3'h7;
		tick(2);
		#1 check(8'({taken, bus_state}), 8'h00);
		check(8'({oe, st}), 8'h0f);
		tick(1);
		cycle_valid <= 1'b0;
	endtask
	initial begin
		srst = 1'b1;
		cycle_valid = 1'b0;
		cycle_kind = 3'h0;
		waits = 4'h0;
		rq_drv = 1'b1;
		err_total = 0;
		tests_run = 0;
		do_reset;
		for (int k = 0; k < 7; k++)
			run_cycle(3'(k), 4'(k % 4));
		hold_seq;
		hold_mid_cycle;
		passive_refused;
		do_reset;
		run_cycle(3'h6, 4'h0);
		tally_and_finish;
	end
	initial begin
		#20000;
		err_total++;
		tally_and_finish;
	end
endmodule
bind bcs_status_encoder bcs_monitor u_bcs_monitor (.core_clk(core_clk), .srst(srst), .cycle_kind(cycle_kind),
	.cycle_taken(cycle_taken), .cycle_end(cycle_end), .bus_state(bus_state),
	.cycle_status_lines(cycle_status_lines), .cycle_status_oe(cycle_status_oe),
	.bus_request_grant_line_in(bus_request_grant_line_in),
	.bus_request_grant_line_oe(bus_request_grant_line_oe), .hold_active(hold_active));
`default_nettype wire
